// [include/nfwp_pkg.sv]
// nfwp_pkg: constants and carrier types for the boot flash write-protect block
// assumes a byte-wide control/status access port on the local bus clock
`default_nettype none
package nfwp_pkg;
   // ----------------------------------------
   // control/status byte layout
   // ----------------------------------------
   localparam int CSR_ADDR_W = 4;
   localparam logic [3:0] NOR_CSR_OFS = 4'h0;
   localparam int SOFT_BIT_POS = 0;
   localparam int SWITCH_BIT_POS = 1;
   localparam logic SOFT_BIT_RST = 1'b1;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // ----------------------------------------
   // bank geometry
   // ----------------------------------------
   localparam int DEV_DATA_W = 16;
   localparam int BANK_DATA_W = 32;
   localparam int NUM_CS = 2;

   typedef struct packed {
      logic cs_n0;
      logic cs_n1;
      logic we_n;
      logic oe_n;
   } nfwp_lb_ctl_t;

   typedef struct packed {
      logic soft_bit;
      logic [7:0] rdata;
   } nfwp_state_t;
endpackage : nfwp_pkg
`default_nettype wire

// [rtl/nfwp_top.sv]
// nfwp_top: write-protect gate for the 32-bit NOR boot flash bank
// assumes local bus strobes and the switch level are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module nfwp_top #(
   parameter int DEV_W = nfwp_pkg::DEV_DATA_W
) (
   input wire logic clk,                               // local bus clock
   input wire logic rst_n,                             // async reset, low
   input wire logic protect_switch_on,                 // hardware switch, 1 = on
   input wire nfwp_pkg::nfwp_lb_ctl_t lb_ctl,          // local bus strobes, low active
   input wire logic csr_sel,                           // csr byte access strobe
   input wire logic csr_wr,                            // 1 write, 0 read
   input wire logic [nfwp_pkg::CSR_ADDR_W-1:0] csr_addr, // byte offset
   input wire logic [7:0] csr_wdata,                   // write byte
   output logic [7:0] csr_rdata,                       // read byte, registered
   output nfwp_pkg::nfwp_lb_ctl_t flash_ctl_lo,        // strobes to low 16-bit device
   output nfwp_pkg::nfwp_lb_ctl_t flash_ctl_hi,        // strobes to high 16-bit device
   output logic flash_protected                        // protection in force
);
   import nfwp_pkg::*;

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   // the bank is exactly two devices side by side; no other strobe wiring exists here
   if (DEV_W <= 0 || DEV_W * 2 != BANK_DATA_W) begin : g_bad_dev_w
      $error("two devices of DEV_W must make the bank width");
   end
   // the local bus carrier holds only two chip-select strobes
   if (NUM_CS != 2) begin : g_bad_num_cs
      $error("the boot bank decodes exactly two chip selects");
   end

   localparam int NUM_DEV = BANK_DATA_W / DEV_W;

   nfwp_state_t st_reg;
   nfwp_state_t st_next;
   logic prot;
   logic bank_sel;
   nfwp_lb_ctl_t gated;
   nfwp_lb_ctl_t dev_ctl [NUM_DEV];
   logic csr_hit;
   logic csr_wr_hit;
   logic csr_rd_any;
   logic soft_clear_req;

   // ----------------------------------------
   // protection decision
   // ----------------------------------------
   // switch dominates; soft bit only counts when the switch is off
   assign prot = protect_switch_on | st_reg.soft_bit;
   assign flash_protected = prot;

   // both chip selects reach the boot bank
   assign bank_sel = ~lb_ctl.cs_n0 | ~lb_ctl.cs_n1;

   always_comb begin
      gated = lb_ctl;
      // write strobe held high while protected; reads untouched
      gated.we_n = lb_ctl.we_n | prot | ~bank_sel;
   end

   // ----------------------------------------
   // per-device strobes
   // ----------------------------------------
   // both 16-bit halves share strobes to form one 32-bit bank; split strobes would tear words
   for (genvar g = 0; g < NUM_DEV; g++) begin : g_dev
      assign dev_ctl[g] = gated;
   end
   assign flash_ctl_lo = dev_ctl[0];
   assign flash_ctl_hi = dev_ctl[NUM_DEV-1];

   // ----------------------------------------
   // control/status byte
   // ----------------------------------------
   assign csr_hit = csr_sel && (csr_addr == NOR_CSR_OFS);
   assign csr_wr_hit = csr_hit && csr_wr;
   assign csr_rd_any = csr_sel && !csr_wr;
   // only a write of zero to the soft bit may ever clear the soft bit
   assign soft_clear_req = csr_wr_hit && !csr_wdata[SOFT_BIT_POS];

   always_comb begin
      st_next = st_reg;
      if (csr_hit) begin
         if (csr_wr) begin
            // switch bit ignores writes
            st_next.soft_bit = csr_wdata[SOFT_BIT_POS];
         end else begin
            st_next.rdata = 8'h00;
            st_next.rdata[SOFT_BIT_POS] = st_reg.soft_bit;
            st_next.rdata[SWITCH_BIT_POS] = protect_switch_on;
         end
      end else if (csr_rd_any) begin
         st_next.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // wake up protected, so a bus glitch during boot cannot write the flash
         st_reg <= '{soft_bit: SOFT_BIT_RST, rdata: RDATA_RST};
      end else begin
         st_reg <= st_next;
      end
   end
   assign csr_rdata = st_reg.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_switch_protects;
      @(posedge clk) disable iff (!rst_n) protect_switch_on |-> flash_protected;
   endproperty
   a_switch_protects: assert property (p_switch_protects)
      else $error("switch on but unprotected");

   property p_soft_decides;
      @(posedge clk) disable iff (!rst_n)
         !protect_switch_on |-> (flash_protected == st_reg.soft_bit);
   endproperty
   a_soft_decides: assert property (p_soft_decides)
      else $error("soft bit not obeyed");

   property p_lift_only_by_clear;
      @(posedge clk) disable iff (!rst_n)
         $fell(st_reg.soft_bit) |-> $past(soft_clear_req);
   endproperty
   a_lift_only_by_clear: assert property (p_lift_only_by_clear)
      else $error("soft bit fell unbidden");

   sequence s_read_csr;
      csr_sel && !csr_wr && csr_addr == NOR_CSR_OFS;
   endsequence
   property p_switch_readback;
      @(posedge clk) disable iff (!rst_n)
         s_read_csr |=> csr_rdata[SWITCH_BIT_POS] == $past(protect_switch_on);
   endproperty
   a_switch_readback: assert property (p_switch_readback)
      else $error("switch status wrong");

   sequence s_write_csr;
      csr_sel && csr_wr && csr_addr == NOR_CSR_OFS;
   endsequence
   property p_soft_readback;
      @(posedge clk) disable iff (!rst_n)
         s_write_csr ##1 s_read_csr |=>
            csr_rdata[SOFT_BIT_POS] == $past(csr_wdata[SOFT_BIT_POS], 2);
   endproperty
   a_soft_readback: assert property (p_soft_readback)
      else $error("soft bit readback wrong");

   property p_no_write_when_prot;
      @(posedge clk) disable iff (!rst_n)
         flash_protected |-> flash_ctl_lo.we_n && flash_ctl_hi.we_n;
   endproperty
   a_no_write_when_prot: assert property (p_no_write_when_prot)
      else $error("write leaked");

   property p_reads_pass;
      @(posedge clk) disable iff (!rst_n)
         flash_ctl_lo.oe_n == lb_ctl.oe_n && flash_ctl_hi.cs_n1 == lb_ctl.cs_n1;
   endproperty
   a_reads_pass: assert property (p_reads_pass)
      else $error("read strobes altered");

   property p_write_passes;
      @(posedge clk) disable iff (!rst_n)
         (!flash_protected && !lb_ctl.we_n && !lb_ctl.cs_n0) |-> !flash_ctl_hi.we_n;
   endproperty
   a_write_passes: assert property (p_write_passes)
      else $error("write wrongly blocked");

   property p_soft_holds;
      @(posedge clk) disable iff (!rst_n)
         !csr_wr_hit |=> $stable(st_reg.soft_bit);
   endproperty
   a_soft_holds: assert property (p_soft_holds)
      else $error("soft bit moved without a write");

   property p_soft_stores;
      @(posedge clk) disable iff (!rst_n)
         s_write_csr |=> st_reg.soft_bit == $past(csr_wdata[SOFT_BIT_POS]);
   endproperty
   a_soft_stores: assert property (p_soft_stores)
      else $error("soft bit did not take the written value");

   property p_lift_needs_switch_off;
      @(posedge clk) disable iff (!rst_n)
         $fell(flash_protected) |-> !protect_switch_on && !st_reg.soft_bit;
   endproperty
   a_lift_needs_switch_off: assert property (p_lift_needs_switch_off)
      else $error("protection lifted with switch on or soft bit set");

   property p_read_upper_zero;
      @(posedge clk) disable iff (!rst_n)
         s_read_csr |=> csr_rdata[7:2] == 6'h00;
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero)
      else $error("unused status bits not zero");

   sequence s_read_other;
      csr_rd_any && csr_addr != NOR_CSR_OFS;
   endsequence
   property p_unmapped_zero;
      @(posedge clk) disable iff (!rst_n)
         s_read_other |=> csr_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_rdata_holds;
      @(posedge clk) disable iff (!rst_n)
         !csr_rd_any |=> $stable(csr_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds)
      else $error("read byte changed without a read");

   property p_no_write_unselected;
      @(posedge clk) disable iff (!rst_n)
         lb_ctl.cs_n0 && lb_ctl.cs_n1 |-> flash_ctl_lo.we_n && flash_ctl_hi.we_n;
   endproperty
   a_no_write_unselected: assert property (p_no_write_unselected)
      else $error("write strobe without chip select");

   property p_halves_match;
      @(posedge clk) disable iff (!rst_n)
         flash_ctl_lo == flash_ctl_hi;
   endproperty
   a_halves_match: assert property (p_halves_match)
      else $error("device strobes differ");
endmodule : nfwp_top
`default_nettype wire

// [dv/nfwp_lbc_model.sv]
// nfwp_bus_ctrl_model: local bus controller issuing one-cycle flash strobes
// assumes requests come from the bench, synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module nfwp_bus_ctrl_model (
   input wire logic clk, // bus clock
   input wire logic rst_n, // async reset, low
   input wire logic req, // one strobe cycle
   input wire logic [2:0] op, // {write, cs1, cs0}
   output var nfwp_pkg::nfwp_lb_ctl_t lb_ctl // strobes, low active
);
   import nfwp_pkg::*;
   // strobes return to idle after one cycle so no stale write lingers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lb_ctl <= 4'hF;
      end else if (req) begin
         lb_ctl <= {~op[0], ~op[1], ~op[2], op[2]};
      end else begin
         lb_ctl <= 4'hF;
      end
   end
endmodule : nfwp_bus_ctrl_model
`default_nettype wire

// [dv/nor_flash_write_protect_bench.sv]
// nor_flash_write_protect_bench: directed checks of the flash write gate
// assumes nfwp_bus_ctrl_model stands in for the local bus controller
`timescale 1ns/10ps
`default_nettype none
module nor_flash_write_protect_bench;
   import nfwp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw = 1'b0;
   logic sel = 1'b0;
   logic wr = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [7:0] wd = 8'h00;
   logic req = 1'b0;
   logic [2:0] op = 3'h0;
   logic [7:0] rd;
   logic prot;
   nfwp_lb_ctl_t lb, lo, hi;
   int miscompares = 0;
   int n_tests = 0;
   always #2.5 clk = ~clk;
   nfwp_bus_ctrl_model nfwp_bus_ctrl_model_inst (.clk(clk), .rst_n(rst_n), .req(req), .op(op),
      .lb_ctl(lb));
   nfwp_top nfwp_top_inst (.clk(clk), .rst_n(rst_n), .protect_switch_on(sw), .lb_ctl(lb),
      .csr_sel(sel), .csr_wr(wr), .csr_addr(adr), .csr_wdata(wd), .csr_rdata(rd),
      .flash_ctl_lo(lo), .flash_ctl_hi(hi), .flash_protected(prot));
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t byte %h exp %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic csr(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      sel <= 1'b0;
      @(posedge clk);
      #1;
   endtask : csr
   // write then read back, csr_sel held high across both bytes
   task automatic csr_wr_rd(input logic [7:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b1;
      adr <= 4'h0;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      sel <= 1'b0;
      #1;
   endtask : csr_wr_rd
   // p is the protection state the bench expects, never read from the design
   task automatic fl(input logic [2:0] o, input logic p);
      logic [3:0] e;
      e = {~o[0], ~o[1], ~o[2] | p | ~|o[1:0], o[2]};
      @(posedge clk);
      req <= 1'b1;
      op <= o;
      @(posedge clk);
      req <= 1'b0;
      #1;
      chk_byte({4'h0, lo}, {4'h0, e});
      chk_byte({4'h0, hi}, {4'h0, e});
   endtask : fl
   task automatic t_reset;
      csr(1'b0, 4'h0, 8'h00);
      chk_byte(rd, 8'h01);
      chk_byte({7'h0, prot}, 8'h01);
      fl(3'b111, 1'b1);
   endtask : t_reset
   task automatic t_matrix;
      logic [1:0] s;
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         @(posedge clk);
         sw <= s[1];
         csr_wr_rd({6'h3F, s[1], s[0]});
         chk_byte(rd, {6'h0, s});
         chk_byte({7'h0, prot}, {7'h0, |s});
         for (int c = 0; c < 4; c++) begin
            fl({1'b1, c[1:0]}, |s);
         end
         fl(3'b001, |s);
      end
   endtask : t_matrix
   task automatic t_unmapped;
      csr(1'b1, 4'h5, 8'h00);
      csr(1'b0, 4'h5, 8'h00);
      chk_byte(rd, 8'h00);
      csr(1'b0, 4'h0, 8'h00);
      chk_byte(rd, {6'h0, sw, 1'b1});
   endtask : t_unmapped
   task automatic print_verdict;
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_matrix();
      t_unmapped();
      print_verdict();
   end
endmodule : nor_flash_write_protect_bench
`default_nettype wire
